// ==== design/usart_spi_pkg.sv ====
// shared constants, mode carrier and helpers for the spi-mode serial channel
// assumes a single peripheral clock domain; pins are synchronised in the top
package usart_spi_pkg;
  localparam int DATA_W = 9;
  localparam int WAIT_W = 16;
  localparam int DIV_W = 16;
  localparam int PRESCALE = 8;
  localparam logic [1:0] CLKSRC_DIV = 2'h1;
  localparam logic [1:0] CLKSRC_EXT = 2'h3;
  localparam logic [3:0] BASE_BITS = 4'h5;
  localparam logic [3:0] NINE_BITS = 4'h9;
  localparam logic [8:0] FULL_MASK = 9'h1FF;
  localparam logic [15:0] WAIT_RST = 16'h0000;

  typedef struct packed {
    logic spi_master;
    logic cpol;
    logic cpha;
    logic nine_bit;
    logic [1:0] char_length_field;
    logic [1:0] clock_source_select;
    logic serial_clock_output_enable;
    logic [DIV_W-1:0] clock_divisor;
  } chan_mode_s;

  typedef enum logic [1:0] {
    SPI_MODE0,
    SPI_MODE1,
    SPI_MODE2,
    SPI_MODE3
  } spi_mode_e;

  function automatic logic [3:0] char_bits(input logic nine,
                                           input logic [1:0] len);
    return nine ? NINE_BITS : BASE_BITS + {2'h0, len};
  endfunction

  function automatic logic [8:0] char_mask(input logic [3:0] nbits);
    return FULL_MASK >> (NINE_BITS - nbits);
  endfunction

  function automatic spi_mode_e proto_mode(input logic cpol,
                                           input logic cpha);
    return spi_mode_e'({cpol, ~cpha});
  endfunction
endpackage

// ==== design/rx_idle_timer.sv ====
// receiver idle time-out: 16-bit down-counter clocked by bit periods
// assumes bit tick, character and command pulses come from the same clock
`timescale 1ns/1ps
module rx_idle_timer (
  input wire logic i_mclk, // peripheral clock
  input wire logic i_reset_n, // synchronous reset, active low
  input wire logic i_bit_tick, // one pulse per bit period
  input wire logic i_char_rx, // character received pulse
  input wire logic i_arm, // arm_wait_on_next_char pulse
  input wire logic i_reload, // reload_restart_wait pulse
  input wire logic [usart_spi_pkg::WAIT_W-1:0] i_wait_value, // idle_wait_value
  output logic o_timeout // idle time-out flag
);
  import usart_spi_pkg::*;

  logic [WAIT_W-1:0] count_reg;
  logic run_reg;
  logic timeout_reg;
  logic disabled;
  logic load;
  logic hit;

  assign disabled = (i_wait_value == WAIT_RST); // see R02
  assign load = i_reload || i_char_rx;
  assign hit = !disabled && run_reg && i_bit_tick && (count_reg == 16'h0001);
  assign o_timeout = timeout_reg;

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      count_reg <= WAIT_RST;
      run_reg <= 1'b0;
    end else if (disabled) begin
      count_reg <= WAIT_RST;
      run_reg <= 1'b0;
    end else if (load) begin
      count_reg <= i_wait_value; // see R03, R06
      run_reg <= 1'b1;
    end else if (i_arm) begin
      run_reg <= 1'b0; // see R05
    end else if (run_reg && i_bit_tick) begin
      count_reg <= count_reg - 16'h0001; // see R03
      if (count_reg == 16'h0001) begin
        run_reg <= 1'b0;
      end
    end
  end

  // a zero crossing in the same cycle as a clearing command still sets
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n || disabled) begin
      timeout_reg <= 1'b0; // see R02
    end else begin
      timeout_reg <= hit || (timeout_reg && !(i_arm || i_reload)); // see R04
    end
  end

  disabled_flag_a: assert property ( // see R02
    @(posedge i_mclk) disable iff (!i_reset_n)
    disabled |=> !timeout_reg) else $error("flag set while disabled");
  reload_load_a: assert property ( // see R06
    @(posedge i_mclk) disable iff (!i_reset_n)
    (i_reload && !disabled) |=> run_reg && count_reg == $past(i_wait_value))
    else $error("reload did not restart");
  arm_stop_a: assert property ( // see R05
    @(posedge i_mclk) disable iff (!i_reset_n)
    (i_arm && !load && !disabled) |=> !run_reg ##1
    ($stable(count_reg) || $past(load) || $past(disabled)))
    else $error("arm did not stop counter");
  zero_flag_a: assert property ( // see R04
    @(posedge i_mclk) disable iff (!i_reset_n)
    hit |=> timeout_reg && (count_reg == WAIT_RST || $past(load || i_arm)))
    else $error("zero reached without flag");
  tick_dec_a: assert property ( // see R03
    @(posedge i_mclk) disable iff (!i_reset_n)
    (run_reg && i_bit_tick && !load && !i_arm && !disabled) |=>
    count_reg == $past(count_reg) - 16'h0001)
    else $error("counter did not decrement");
  timeout_seen_c: cover property (@(posedge i_mclk) disable iff (!i_reset_n)
    hit ##1 timeout_reg);
endmodule

// ==== design/usart_spi_channel.sv ====
// spi-mode serial channel with receiver idle time-out
// assumes mode and command inputs come from logic on i_mclk; pins are async
//
// Contract
// R01: detect receive idle, raise idle time-out flag to mark end of frame.
// R02: zero wait value disables time-out detection and holds the flag low.
// R03: nonzero value loads 16-bit counter, decrements per bit, reloads per char.
// R04: counter reaching zero sets the idle time-out flag.
// R05: arm command stops counter until next character; no early time-out.
// R06: reload command restarts countdown immediately for periodic time-outs.
// R07: spi baud generator works as in synchronous mode.
// R08: master software avoids external clock select and enables clock output.
// R09: master software programs clock divisor of at least six.
// R10: divided clock needs even divisor for 50:50 duty; odd allowed otherwise.
// R11: slave uses external serial clock, ignoring source select and divisor.
// R12: external master keeps serial clock six times below system clock.
// R13: shift up to nine data bits with no start, parity or stop.
// R14: length field sets bit count; nine-bit control forces nine bits.
// R15: most significant bit always goes out first.
// R16: four modes map polarity and phase as 0:01, 1:00, 2:11, 3:10.
// R17: master and slave use matching polarity and phase settings.
`timescale 1ns/1ps
module usart_spi_channel (
  input wire logic i_mclk, // peripheral clock, 250 MHz
  input wire logic i_reset_n, // synchronous reset, active low
  input usart_spi_pkg::chan_mode_s i_mode, // channel mode fields
  input wire logic [usart_spi_pkg::WAIT_W-1:0] i_idle_wait_value, // wait
  input wire logic i_arm_wait_on_next_char, // command pulse
  input wire logic i_reload_restart_wait, // command pulse
  input wire logic [usart_spi_pkg::DATA_W-1:0] i_tx_data, // character out
  input wire logic i_tx_valid, // character offered
  output logic o_tx_ready, // character accepted when valid
  output logic [usart_spi_pkg::DATA_W-1:0] o_rx_data, // character in
  output logic o_rx_valid, // one-cycle receive pulse
  output logic o_idle_timeout, // idle time-out status flag
  output usart_spi_pkg::spi_mode_e o_protocol_mode, // current bus mode
  input wire logic i_rxd, // receive data pin
  output logic o_txd, // transmit data pin
  input wire logic i_sck, // serial clock pin, input side
  output logic o_sck, // serial clock pin, output side
  output logic o_sck_oe, // serial clock drive enable, high drives
  input wire logic i_sel_n // slave select pin, active low
);
  import usart_spi_pkg::*;

  typedef enum logic {ST_IDLE, ST_SHIFT} xfer_e;

  logic rxd_s1, rxd_s2, sck_s1, sck_s2, sck_s3, sel_s1, sel_s2;
  logic [$clog2(PRESCALE)-1:0] pre_cnt_reg;
  logic [DIV_W-1:0] div_cnt_reg;
  logic sck_reg, oe_reg;
  xfer_e state_reg;
  logic [3:0] bit_cnt_reg;
  logic first_change_reg;
  logic loaded_reg;
  logic [DATA_W-1:0] tx_shift_reg, rx_shift_reg, rx_data_reg;
  logic rx_valid_reg, tx_ready_reg;
  spi_mode_e mode_reg;
  logic [3:0] nbits;
  logic src_tick, wrap_ev, half_ev, gen_edge, master;
  logic lead_ev, trail_ev, sample_ev, change_ev, char_done, master_end;
  logic tx_take, bit_tick;
  logic [DATA_W-1:0] tx_just;

  // pin synchronisers; the second stage feeds logic, and a third sck stage feeds edge detection
  always_ff @(posedge i_mclk) begin
    rxd_s1 <= i_rxd;
    rxd_s2 <= rxd_s1;
    sck_s1 <= i_sck;
    sck_s2 <= sck_s1;
    sck_s3 <= sck_s2;
    sel_s1 <= i_sel_n;
    sel_s2 <= sel_s1;
  end

  assign master = i_mode.spi_master;
  assign nbits = char_bits(i_mode.nine_bit,
                           i_mode.char_length_field); // see R14
  assign tx_just = i_tx_data << (NINE_BITS - nbits); // see R15
  assign tx_take = tx_ready_reg && i_tx_valid;

  // baud generator: source clock is the peripheral clock or its prescaled copy
  assign src_tick = (i_mode.clock_source_select != CLKSRC_DIV) ||
                    (pre_cnt_reg == ($clog2(PRESCALE))'(PRESCALE - 1));
  assign wrap_ev = src_tick && (i_mode.clock_divisor != '0) &&
                   ((div_cnt_reg + 16'h0001) == i_mode.clock_divisor);
  // odd divisors give an uneven duty; software keeps them even when prescaled
  assign half_ev = src_tick && (i_mode.clock_divisor > 16'h0001) &&
                   ((div_cnt_reg + 16'h0001) == (i_mode.clock_divisor >> 1));
  assign gen_edge = master && (state_reg == ST_SHIFT) && (wrap_ev || half_ev);

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      pre_cnt_reg <= '0;
      div_cnt_reg <= '0;
    end else begin
      pre_cnt_reg <= src_tick ? '0 : pre_cnt_reg + 1'b1; // see R07
      if (wrap_ev) begin
        div_cnt_reg <= '0;
      end else if (src_tick) begin
        div_cnt_reg <= div_cnt_reg + 16'h0001;
      end
    end
  end

  // edge events: generated in master, synchronised pin edges in slave
  always_comb begin
    if (master) begin
      lead_ev = gen_edge && (sck_reg == i_mode.cpol);
      trail_ev = gen_edge && (sck_reg != i_mode.cpol);
    end else begin
      lead_ev = (state_reg == ST_SHIFT) && (sck_s2 != sck_s3) &&
                (sck_s3 == i_mode.cpol); // see R11
      trail_ev = (state_reg == ST_SHIFT) && (sck_s2 != sck_s3) &&
                 (sck_s3 != i_mode.cpol);
    end
  end

  // cpha high samples on the leading edge, low samples on the trailing one
  assign sample_ev = i_mode.cpha ? lead_ev : trail_ev; // see R16
  assign change_ev = i_mode.cpha ? trail_ev : lead_ev;
  assign char_done = sample_ev && (bit_cnt_reg == nbits - 4'h1); // see R13
  assign master_end = master && trail_ev &&
                      (bit_cnt_reg == nbits || char_done);
  // slave bit periods follow the external clock, master ones the generator
  assign bit_tick = master ? wrap_ev : lead_ev;

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      state_reg <= ST_IDLE;
    end else if (master) begin
      if (state_reg == ST_IDLE && loaded_reg) begin
        state_reg <= ST_SHIFT;
      end else if (master_end) begin
        state_reg <= ST_IDLE;
      end
    end else begin
      state_reg <= sel_s2 ? ST_IDLE : ST_SHIFT;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      sck_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else begin
      oe_reg <= master && i_mode.serial_clock_output_enable; // see R11
      if (!master || state_reg == ST_IDLE) begin
        sck_reg <= i_mode.cpol;
      end else if (gen_edge) begin
        sck_reg <= !sck_reg;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n || state_reg == ST_IDLE || master_end) begin
      bit_cnt_reg <= 4'h0;
    end else if (char_done) begin
      bit_cnt_reg <= master ? nbits : 4'h0;
    end else if (sample_ev) begin
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
    end
  end

  // transmit: left-justified so the top bit is always the next one out
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      tx_shift_reg <= '0;
      loaded_reg <= 1'b0;
      first_change_reg <= 1'b1;
      tx_ready_reg <= 1'b0;
    end else begin
      tx_ready_reg <= !loaded_reg && !tx_take &&
                      (!master || state_reg == ST_IDLE);
      if (tx_take) begin
        tx_shift_reg <= tx_just; // see R15
        loaded_reg <= 1'b1;
        first_change_reg <= 1'b1;
      end else if (state_reg == ST_IDLE) begin
        first_change_reg <= 1'b1;
        if (master && loaded_reg) begin
          loaded_reg <= 1'b0;
        end
      end else if (!master && char_done) begin
        // the queued character has just gone out; idle characters send zeros
        tx_shift_reg <= '0;
        loaded_reg <= 1'b0;
        first_change_reg <= 1'b1;
      end else if (change_ev) begin
        first_change_reg <= 1'b0;
        if (!(first_change_reg && !i_mode.cpha)) begin
          tx_shift_reg <= tx_shift_reg << 1; // see R13
        end
      end
    end
  end

  // receive
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      rx_shift_reg <= '0;
      rx_data_reg <= '0;
      rx_valid_reg <= 1'b0;
    end else begin
      rx_valid_reg <= char_done;
      if (sample_ev) begin
        rx_shift_reg <= {rx_shift_reg[DATA_W-2:0], rxd_s2};
      end
      if (char_done) begin
        rx_data_reg <= {rx_shift_reg[DATA_W-2:0], rxd_s2} &
                       char_mask(nbits); // see R14
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      mode_reg <= SPI_MODE0;
    end else begin
      mode_reg <= proto_mode(i_mode.cpol, i_mode.cpha); // see R16
    end
  end

  rx_idle_timer u_idle_timer (
    .i_mclk(i_mclk),
    .i_reset_n(i_reset_n),
    .i_bit_tick(bit_tick),
    .i_char_rx(char_done), // see R03
    .i_arm(i_arm_wait_on_next_char), // see R05
    .i_reload(i_reload_restart_wait), // see R06
    .i_wait_value(i_idle_wait_value),
    .o_timeout(o_idle_timeout) // see R01
  );

  assign o_tx_ready = tx_ready_reg;
  assign o_rx_data = rx_data_reg;
  assign o_rx_valid = rx_valid_reg;
  assign o_protocol_mode = mode_reg;
  assign o_txd = tx_shift_reg[DATA_W-1];
  assign o_sck = sck_reg;
  assign o_sck_oe = oe_reg;

  msb_first_a: assert property ( // see R15
    @(posedge i_mclk) disable iff (!i_reset_n)
    tx_take |=> o_txd == $past(i_tx_data[nbits - 4'h1]))
    else $error("first bit out is not the msb");
  slave_clock_a: assert property ( // see R11
    @(posedge i_mclk) disable iff (!i_reset_n)
    !master |=> !o_sck_oe && o_sck == $past(i_mode.cpol))
    else $error("slave drives serial clock");
  // the reset edge itself is skipped: the mode register holds its reset value
  mode_map_a: assert property ( // see R16
    @(posedge i_mclk) disable iff (!i_reset_n)
    i_reset_n |=> o_protocol_mode == ($past(i_mode.cpol) ?
    ($past(i_mode.cpha) ? SPI_MODE2 : SPI_MODE3) :
    ($past(i_mode.cpha) ? SPI_MODE0 : SPI_MODE1)))
    else $error("wrong protocol mode");
  char_len_a: assert property ( // see R14
    @(posedge i_mclk) disable iff (!i_reset_n)
    o_rx_valid |-> (o_rx_data & ~$past(char_mask(nbits))) == '0)
    else $error("received bits beyond length");
  rx_after_sample_a: assert property ( // see R13
    @(posedge i_mclk) disable iff (!i_reset_n)
    o_rx_valid |-> $past(sample_ev) &&
    $past(bit_cnt_reg) == $past(nbits) - 4'h1)
    else $error("character ended off count");
  idle_clock_a: assert property ( // see R07
    @(posedge i_mclk) disable iff (!i_reset_n)
    (master && state_reg == ST_IDLE) |=> o_sck == $past(i_mode.cpol))
    else $error("master clock not idle at polarity");
  master_char_c: cover property (@(posedge i_mclk) disable iff (!i_reset_n)
    master && tx_take ##[1:400] master_end);
  slave_char_c: cover property (@(posedge i_mclk) disable iff (!i_reset_n)
    !master && o_rx_valid);
  mode3_c: cover property (@(posedge i_mclk) disable iff (!i_reset_n)
    o_protocol_mode == SPI_MODE3 && o_rx_valid);
endmodule

// ==== testbench/spi_peer_model.sv ====
// spi peer that faces the channel when the channel is master
// assumes the clock pin is driven by the channel and settings match it
`timescale 1ns/1ps
module spi_peer_model (
  input wire logic i_sck, // serial clock pin
  input wire logic i_txd, // data from the channel
  input wire logic i_cpol, // polarity, kept equal to the channel
  input wire logic i_cpha, // phase, kept equal to the channel
  input wire logic [3:0] i_nbits, // bits per character
  input wire logic [8:0] i_word, // character sent back
  input wire logic i_load, // rising edge arms a new character
  output logic o_rxd, // data to the channel
  output logic [8:0] o_got, // captured, first bit ends up msb
  output logic [3:0] o_count // sample edges seen
);
  logic lead;
  initial begin
    o_rxd = 1'b0;
    o_got = 9'h000;
    o_count = 4'h0;
  end
  always @(posedge i_load) begin
    o_count = 4'h0;
    o_got = 9'h000;
    o_rxd = i_word[i_nbits-1];
  end
  always @(i_sck) begin
    lead = (i_sck !== i_cpol);
    if (lead == i_cpha) begin
      o_got = {o_got[7:0], i_txd};
      o_count = o_count + 4'h1;
    end else if (o_count >= i_nbits) begin
      // past the character: never leave a stale bit on the line
      o_rxd = ~o_rxd;
    end else if (o_count != 4'h0) begin
      o_rxd = i_word[i_nbits-1-o_count];
    end
  end
endmodule

// ==== testbench/usart_spi_channel_tb.sv ====
// self-checking bench for the spi-mode channel and its idle timer
// assumes the peer model on the pins when master, bench pins when slave
`timescale 1ns/1ps
module usart_spi_channel_tb;
  import usart_spi_pkg::*;
  localparam int W = 5; // idle wait in bit periods
  localparam int D = 10; // even divisor, at least six
  localparam int H = 8; // slave half period, well below clock/6
  logic clk, rst_n, arm, rl, tv, tx_ready, rx_valid, tmo, txd, sck_o;
  logic sck_oe, tb_sck, sel_n, tb_rxd, load;
  chan_mode_s md;
  spi_mode_e pm;
  logic [15:0] wv;
  logic [8:0] td, rx_data, rx_last, peer_word, got, cap;
  logic [3:0] nb, cnt;
  wire peer_rxd;
  wire sck_pin = sck_oe ? sck_o : tb_sck;
  wire rxd_pin = md.spi_master ? peer_rxd : tb_rxd;
  int fail_count = 0, n_compared = 0, n_rx = 0, k, r;

  always #2 clk = ~clk;
  always @(negedge clk) if (rx_valid === 1'b1) begin
    rx_last = rx_data;
    n_rx++;
  end

  usart_spi_channel usart_spi_channel_i (.i_mclk(clk), .i_reset_n(rst_n),
    .i_mode(md), .i_idle_wait_value(wv), .i_arm_wait_on_next_char(arm),
    .i_reload_restart_wait(rl), .i_tx_data(td), .i_tx_valid(tv),
    .o_tx_ready(tx_ready), .o_rx_data(rx_data), .o_rx_valid(rx_valid),
    .o_idle_timeout(tmo), .o_protocol_mode(pm), .i_rxd(rxd_pin),
    .o_txd(txd), .i_sck(sck_pin), .o_sck(sck_o), .o_sck_oe(sck_oe),
    .i_sel_n(sel_n));
  spi_peer_model spi_peer_model_i (.i_sck(sck_pin), .i_txd(txd),
    .i_cpol(md.cpol), .i_cpha(md.cpha), .i_nbits(nb), .i_word(peer_word),
    .i_load(load), .o_rxd(peer_rxd), .o_got(got), .o_count(cnt));

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic pulse(input bit reload);
    @(posedge clk);
    if (reload) rl <= 1'b1;
    else arm <= 1'b1;
    @(posedge clk);
    rl <= 1'b0;
    arm <= 1'b0;
    tick(1);
  endtask
  task automatic set_mode(input logic m, pol, pha, nine,
                          input logic [1:0] len, src, input logic [15:0] dv);
    @(posedge clk);
    md <= '{m, pol, pha, nine, len, src, m, dv};
    tb_sck <= pol;
    tick(40);
  endtask
  task automatic offer(input logic [8:0] d);
    @(posedge clk);
    td <= d;
    tv <= 1'b1;
    k = 0;
    do begin
      tick(1);
      k++;
    end while (tx_ready !== 1'b1 && k < 3000);
    chk("tx ready", 16'h1, 16'(tx_ready));
    @(posedge clk);
    tv <= 1'b0;
  endtask
  task automatic mxfer(input logic [8:0] d, pw, input logic [3:0] n);
    logic [8:0] msk;
    msk = 9'h1FF >> (9 - n);
    nb = n;
    peer_word = pw;
    load = 1'b1;
    tick(1);
    load = 1'b0;
    r = n_rx;
    offer(d);
    k = 0;
    while (n_rx == r && k < 3000) begin tick(1); k++; end
    chk("rx done", 16'(r + 1), 16'(n_rx));
    chk("rx data", 16'(pw & msk), 16'(rx_last));
    chk("peer capture", 16'(d & msk), 16'(got));
    tick(20);
    chk("bit count", 16'(n), 16'(cnt));
    chk("idle clock", 16'(md.cpol), 16'(sck_o));
  endtask
  task automatic sframe(input logic [8:0] mw, input logic [3:0] n);
    cap = 9'h000;
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge clk);
      if (!md.cpha) tb_sck <= ~tb_sck;
      tb_rxd <= mw[i];
      repeat (H - 1) @(posedge clk);
      tick(1);
      cap = {cap[7:0], txd};
      @(posedge clk);
      tb_sck <= ~tb_sck;
      repeat (H) @(posedge clk);
      if (md.cpha) tb_sck <= ~tb_sck;
    end
    tick(H);
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    report_and_stop();
  end
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    md = '0;
    wv = 16'h0000;
    {arm, rl, tv, tb_sck, tb_rxd, load} = '0;
    sel_n = 1'b1;
    td = 9'h000;
    nb = 4'h5;
    peer_word = 9'h000;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    set_mode(1, 0, 1, 0, 2'h0, 2'h0, 16'(D));
    pulse(1);
    tick(100);
    chk("timer off", 16'h0, 16'(tmo));
    @(posedge clk);
    wv <= 16'(W);
    pulse(1);
    tick((W - 1) * D - 1);
    chk("timer early", 16'h0, 16'(tmo));
    tick(D + 5);
    chk("timer flag", 16'h1, 16'(tmo));
    tick(50);
    chk("timer sticky", 16'h1, 16'(tmo));
    pulse(1);
    pulse(0);
    tick(4 * W * D);
    chk("timer armed", 16'h0, 16'(tmo));
    mxfer(9'h1B4, 9'h0E9, 4'h5);
    tick(15);
    chk("char reload", 16'h0, 16'(tmo));
    tick(20);
    chk("char timeout", 16'h1, 16'(tmo));
    @(posedge clk);
    wv <= 16'h0000;
    tick(2);
    chk("timer zero", 16'h0, 16'(tmo));
    $display("test idle timer done");
    for (int m = 0; m < 4; m++) begin
      set_mode(1, m[1], ~m[0], m == 0 || m == 3,
               m == 2 ? 2'h3 : (m == 3 ? 2'h2 : 2'h0),
               m == 3 ? CLKSRC_DIV : 2'h0, 16'(D));
      chk("bus mode", 16'(m), 16'(pm));
      chk("sck master drive", 16'h1, 16'(sck_oe));
      mxfer(9'h1B4, 9'h1E9,
            (m == 0 || m == 3) ? 4'h9 : (m == 2 ? 4'h8 : 4'h5));
    end
    $display("test master modes done");
    set_mode(0, 1, 0, 0, 2'h3, CLKSRC_DIV, 16'h0000);
    chk("sck drive", 16'h0, 16'(sck_oe));
    offer(9'h1C3);
    @(posedge clk);
    sel_n <= 1'b0;
    tick(4);
    sframe(9'h05A, 4'h8);
    chk("slave rx 1", 16'h005A, 16'(rx_last));
    chk("slave tx", 16'h00C3, 16'(cap));
    sframe(9'h1A6, 4'h8);
    chk("slave rx 2", 16'h00A6, 16'(rx_last));
    chk("slave tx idle", 16'h0000, 16'(cap));
    @(posedge clk);
    sel_n <= 1'b1;
    $display("test slave done");
    report_and_stop();
  end
endmodule
